// ---- dsr_status_cfg.svh ----
// constants for the display status readback bank: offsets, bit positions, resets, timing
// assumes a byte-wide register port and a 50 MHz core clock
// How it works
// (R1) image-mode gamma field reads 000 (curve one)
// (R2) signal-mode byte: only bits 7,6,0 live
// (R3) signal-mode bit 7 shows tearing line enabled
// (R4) signal-mode bit 6: mode1 zero, mode2 one
// (R5) signal-mode bit 0 flags serial link error
// (R6) status reads answered awake, idle, or asleep
// (R7) diag byte reflects most recent wake result
// (R8) diag bit 7 toggles on nonvolatile load match
// (R9) diag bit 6 toggles when functionality passes
// (R10) diag bit 0: checksums equal zero, else one
// (R11) host waits 300 ms after page-zero write
// (R12) diagnostics run during 5 ms after wake
`ifndef DSR_STATUS_CFG_SVH
`define DSR_STATUS_CFG_SVH
`define DSR_ADDR_IMAGE_MODE 8'h0d
`define DSR_ADDR_SIGNAL_MODE 8'h0e
`define DSR_ADDR_SELF_DIAG 8'h0f
`define DSR_ADDR_INT_STATUS 8'h80
`define DSR_ADDR_INT_MASK 8'h81
`define DSR_ADDR_SYS_STATUS 8'h82
`define DSR_PAGE0_LIMIT 8'h80
`define DSR_RESET_BYTE 8'h00
`define DSR_GAMMA_CURVE1 3'h0
`define DSR_BIT_TE_ENABLE 7
`define DSR_BIT_TE_MODE 6
`define DSR_BIT_LINK_ERROR 0
`define DSR_BIT_NVM_MATCH 7
`define DSR_BIT_FUNC_PASS 6
`define DSR_BIT_CSUM_DIFF 0
`define DSR_INT_LINK_ERROR 0
`define DSR_INT_DIAG_DONE 1
`define DSR_INT_CSUM_SETTLED 2
`define DSR_INT_WIDTH 3
`define DSR_CLK_KHZ 50000
`define DSR_SETTLE_MS 5
`define DSR_CSUM_WAIT_MS 300
`define DSR_SETTLE_CYCLES (`DSR_SETTLE_MS * `DSR_CLK_KHZ)
`define DSR_CSUM_WAIT_CYCLES (`DSR_CSUM_WAIT_MS * `DSR_CLK_KHZ)
`define DSR_COUNT_WIDTH 24
`endif

// ---- dsr_status_pkg.sv ----
// types for the display status readback bank
// assumes dsr_status_cfg.svh supplies the numbers
package dsr_status_pkg;
  // power state of the panel driver, gray coded along sleep -> settle -> awake
  typedef enum logic [1:0] {
    DSR_ASLEEP = 2'b00,
    DSR_SETTLE = 2'b01,
    DSR_AWAKE = 2'b11
  } dsr_power_t;
  // register port address
  typedef logic [7:0] dsr_addr_t;
  // one status byte
  typedef logic [7:0] dsr_byte_t;
endpackage

// ---- dsr_status_bank.sv ----
// display status readback bank: signal-mode, image-mode and self-diagnostic bytes
// assumes a command decoder feeds wake/sleep strobes and a register port with one-cycle strobes
`timescale 1ns/100ps
`default_nettype none
`include "dsr_status_cfg.svh"

module dsr_status_bank #(
  parameter int SETTLE_CYCLES = `DSR_SETTLE_CYCLES, // wake settle window
  parameter int CSUM_WAIT_CYCLES = `DSR_CSUM_WAIT_CYCLES // checksum quiet time
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire dsr_status_pkg::dsr_addr_t regAddr,
  input wire dsr_status_pkg::dsr_byte_t regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output dsr_status_pkg::dsr_byte_t regRdData,
  input wire logic teLineEnable,
  input wire logic teLineMode,
  input wire logic linkErrorEvent,
  input wire logic wakeCmd,
  input wire logic sleepCmd,
  input wire logic page0LinkWrite,
  input wire logic nvmLoadMatch,
  input wire logic funcCheckPass,
  input wire logic checksumDiffer,
  output logic diagBusy,
  output logic asleep,
  output logic irq
);

  // power state and its next value
  dsr_status_pkg::dsr_power_t powerState;
  dsr_status_pkg::dsr_power_t next_powerState;
  // settle window counter
  logic [`DSR_COUNT_WIDTH-1:0] settleCount;
  // checksum quiet-time counter and its flag
  logic [`DSR_COUNT_WIDTH-1:0] csumCount;
  logic csumSettled;
  logic csumSettledDly; // previous value, for the rising event
  // sticky link error shown in the signal-mode byte
  logic linkError;
  // self-diagnostic result byte
  dsr_status_pkg::dsr_byte_t diagResult;
  // interrupt status and mask
  logic [`DSR_INT_WIDTH-1:0] intStatus;
  logic [`DSR_INT_WIDTH-1:0] intMask;
  // events in this cycle
  logic diagDone;
  logic page0Write;
  logic [`DSR_INT_WIDTH-1:0] intEvent;
  logic [`DSR_INT_WIDTH-1:0] intClear;
  logic [`DSR_INT_WIDTH-1:0] next_intStatus;

  // true for the command-page-zero address range
  function automatic logic isPage0(input dsr_status_pkg::dsr_addr_t a);
    isPage0 = (a < `DSR_PAGE0_LIMIT);
  endfunction

  // read decode shared by the read data path and the clear-on-read of the link error
  function automatic logic isSignalMode(input dsr_status_pkg::dsr_addr_t a);
    isSignalMode = (a == `DSR_ADDR_SIGNAL_MODE);
  endfunction

  // settle ends on the last counted cycle
  assign diagDone = (powerState == dsr_status_pkg::DSR_SETTLE) &&
                    (settleCount == `DSR_COUNT_WIDTH'(SETTLE_CYCLES - 1));
  // any page-zero write, from the link decoder or the register port
  assign page0Write = page0LinkWrite || (regWrite && isPage0(regAddr));

  // power state next value; wake is ignored unless asleep
  always_comb begin
    next_powerState = powerState;
    case (powerState)
      dsr_status_pkg::DSR_ASLEEP: begin
        if (wakeCmd) begin
          next_powerState = dsr_status_pkg::DSR_SETTLE; // [R12]
        end
      end
      dsr_status_pkg::DSR_SETTLE: begin
        // sleep cannot cut the settle window short: the supplies are ramping
        if (diagDone) begin
          next_powerState = dsr_status_pkg::DSR_AWAKE;
        end
      end
      dsr_status_pkg::DSR_AWAKE: begin
        if (sleepCmd) begin
          next_powerState = dsr_status_pkg::DSR_ASLEEP;
        end
      end
      default: begin
        next_powerState = dsr_status_pkg::DSR_ASLEEP;
      end
    endcase
  end

  // power state register; the part starts asleep
  always_ff @(posedge core_clk) begin
    if (reset) begin
      powerState <= dsr_status_pkg::DSR_ASLEEP;
    end else begin
      powerState <= next_powerState;
    end
  end

  // settle counter, runs only inside the window
  always_ff @(posedge core_clk) begin
    if (reset) begin
      settleCount <= '0;
    end else if (powerState == dsr_status_pkg::DSR_SETTLE && !diagDone) begin
      settleCount <= settleCount + 1'b1; // [R12]
    end else begin
      settleCount <= '0;
    end
  end

  // self-diagnostic byte, updated at the end of each wake window
  always_ff @(posedge core_clk) begin
    if (reset) begin
      diagResult <= `DSR_RESET_BYTE;
    end else if (diagDone) begin
      // toggling keeps the previous result visible as the other polarity
      diagResult[`DSR_BIT_NVM_MATCH] <= diagResult[`DSR_BIT_NVM_MATCH] ^ nvmLoadMatch; // [R8]
      diagResult[`DSR_BIT_FUNC_PASS] <= diagResult[`DSR_BIT_FUNC_PASS] ^ funcCheckPass; // [R9]
      diagResult[`DSR_BIT_CSUM_DIFF] <= checksumDiffer; // [R10] [R7]
    end else if (powerState == dsr_status_pkg::DSR_AWAKE && csumSettled) begin
      // once quiet and awake, the checksum bit follows the live comparison
      diagResult[`DSR_BIT_CSUM_DIFF] <= checksumDiffer; // [R10]
    end
  end

  // checksum quiet-time: restarted by every page-zero write
  always_ff @(posedge core_clk) begin
    if (reset) begin
      csumCount <= '0;
      csumSettled <= 1'b1;
    end else if (page0Write) begin
      // the host is still required to wait; this reports when it may read and holds the checksum bit until then
      csumCount <= `DSR_COUNT_WIDTH'(CSUM_WAIT_CYCLES - 1); // [R11]
      csumSettled <= 1'b0;
    end else if (csumCount != '0) begin
      csumCount <= csumCount - 1'b1;
    end else begin
      csumSettled <= 1'b1;
    end
  end

  // delayed copy for the settled edge
  always_ff @(posedge core_clk) begin
    if (reset) begin
      csumSettledDly <= 1'b1;
    end else begin
      csumSettledDly <= csumSettled;
    end
  end

  // sticky link error; a new error beats the clear-on-read in the same cycle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      linkError <= 1'b0;
    end else if (linkErrorEvent) begin
      linkError <= 1'b1; // [R5]
    end else if (regRead && isSignalMode(regAddr)) begin
      linkError <= 1'b0;
    end
  end

  // interrupt events and write-one-to-clear
  always_comb begin
    intEvent = '0;
    intEvent[`DSR_INT_LINK_ERROR] = linkErrorEvent;
    intEvent[`DSR_INT_DIAG_DONE] = diagDone;
    intEvent[`DSR_INT_CSUM_SETTLED] = csumSettled && !csumSettledDly;
    intClear = '0;
    if (regWrite && regAddr == `DSR_ADDR_INT_STATUS) begin
      intClear = regWrData[`DSR_INT_WIDTH-1:0];
    end
    // set wins over clear
    next_intStatus = (intStatus & ~intClear) | intEvent;
  end

  // interrupt status register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      intStatus <= '0;
    end else begin
      intStatus <= next_intStatus;
    end
  end

  // interrupt mask register, written by software
  always_ff @(posedge core_clk) begin
    if (reset) begin
      intMask <= '0;
    end else if (regWrite && regAddr == `DSR_ADDR_INT_MASK) begin
      intMask <= regWrData[`DSR_INT_WIDTH-1:0];
    end
  end

  // interrupt level output, one cycle behind the status
  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(intStatus & intMask);
    end
  end

  // state outputs, registered
  always_ff @(posedge core_clk) begin
    if (reset) begin
      diagBusy <= 1'b0;
      asleep <= 1'b1;
    end else begin
      diagBusy <= (next_powerState == dsr_status_pkg::DSR_SETTLE);
      asleep <= (next_powerState == dsr_status_pkg::DSR_ASLEEP);
    end
  end

  // read data: one cycle after the strobe, zero otherwise; no power-state gating
  always_ff @(posedge core_clk) begin
    if (reset) begin
      regRdData <= `DSR_RESET_BYTE;
    end else if (!regRead) begin
      regRdData <= `DSR_RESET_BYTE;
    end else if (regAddr == `DSR_ADDR_IMAGE_MODE) begin
      // only the gamma field is kept here; a single curve exists
      regRdData <= {5'h00, `DSR_GAMMA_CURVE1}; // [R1] [R6]
    end else if (isSignalMode(regAddr)) begin
      regRdData <= {teLineEnable, teLineMode, 5'h00, linkError}; // [R2] [R3] [R4] [R5] [R6]
    end else if (regAddr == `DSR_ADDR_SELF_DIAG) begin
      regRdData <= {diagResult[7:6], 5'h00, diagResult[0]}; // [R7] [R6]
    end else if (regAddr == `DSR_ADDR_INT_STATUS) begin
      regRdData <= {5'h00, intStatus};
    end else if (regAddr == `DSR_ADDR_INT_MASK) begin
      regRdData <= {5'h00, intMask};
    end else if (regAddr == `DSR_ADDR_SYS_STATUS) begin
      regRdData <= {5'h00, csumSettled, powerState};
    end else begin
      // unmapped reads return zero
      regRdData <= `DSR_RESET_BYTE;
    end
  end

  // checks, clocked on the core clock, idle during reset
  default clocking dsrCk @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // wake from sleep then eight cycles in the settle window
  sequence wakeSeq;
    (powerState == dsr_status_pkg::DSR_ASLEEP) && wakeCmd;
  endsequence
  sequence settleSeq;
    (powerState == dsr_status_pkg::DSR_SETTLE) [*8];
  endsequence

  gamma_field_a: assert property ( // [R1]
    regRead && regAddr == `DSR_ADDR_IMAGE_MODE |=> regRdData[2:0] == 3'h0)
    else $error("gamma field not curve one");

  sig_zero_bits_a: assert property ( // [R2]
    regRead && isSignalMode(regAddr) |=> regRdData[5:1] == 5'h00)
    else $error("signal-mode reserved bits not zero");

  te_enable_bit_a: assert property ( // [R3]
    regRead && isSignalMode(regAddr) |=> regRdData[7] == $past(teLineEnable))
    else $error("tearing enable bit wrong");

  te_mode_bit_a: assert property ( // [R4]
    regRead && isSignalMode(regAddr) |=> regRdData[6] == $past(teLineMode))
    else $error("tearing mode bit wrong");

  link_error_a: assert property ( // [R5]
    linkErrorEvent |=> linkError)
    else $error("link error not reported");

  read_any_state_a: assert property ( // [R6]
    regRead && regAddr == `DSR_ADDR_SELF_DIAG |=>
      regRdData == {$past(diagResult[7:6]), 5'h00, $past(diagResult[0])})
    else $error("diag read refused");

  diag_hold_a: assert property ( // [R7]
    powerState == dsr_status_pkg::DSR_ASLEEP |=> $stable(diagResult))
    else $error("diag byte changed while asleep");

  nvm_toggle_a: assert property ( // [R8]
    diagDone |=> diagResult[7] == ($past(diagResult[7]) ^ $past(nvmLoadMatch)))
    else $error("load-match bit not toggled");

  func_toggle_a: assert property ( // [R9]
    diagDone |=> diagResult[6] == ($past(diagResult[6]) ^ $past(funcCheckPass)))
    else $error("function bit not toggled");

  csum_bit_a: assert property ( // [R10]
    diagDone |=> diagResult[0] == $past(checksumDiffer))
    else $error("checksum bit wrong");

  settle_start_a: assert property ( // [R12]
    wakeSeq |=> settleSeq or (diagBusy ##[1:7] diagDone))
    else $error("settle window not entered");

  // helper: cycles spent in the settle window, kept apart from the design counter
  // so that a stuck settle counter still trips the overrun check
  logic [`DSR_COUNT_WIDTH-1:0] settleAge;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      settleAge <= '0;
    end else if (powerState == dsr_status_pkg::DSR_SETTLE) begin
      settleAge <= settleAge + 1'b1;
    end else begin
      settleAge <= '0;
    end
  end

  settle_length_a: assert property ( // [R12]
    powerState == dsr_status_pkg::DSR_SETTLE |->
      settleAge < `DSR_COUNT_WIDTH'(SETTLE_CYCLES))
    else $error("settle window overran");

  csum_restart_a: assert property ( // [R11]
    page0Write |=> !csumSettled)
    else $error("checksum quiet time not restarted");

endmodule
`default_nettype wire

// ---- dsr_link_host.sv ----
// link-side host model: wake/sleep commands, link errors, page-zero writes
// assumes the bench calls send() from one process, one command at a time
`timescale 1ns/100ps
`default_nettype none
module dsr_link_host #(
  parameter int QUIET = 20 // cycles to wait after a page-zero write
) (
  input wire logic core_clk,
  output logic wakeCmd,
  output logic sleepCmd,
  output logic page0LinkWrite,
  output logic linkErrorEvent,
  output logic csumReadOk
);
  int quiet = 0; // cycles since the last page-zero write
  initial {wakeCmd, sleepCmd, page0LinkWrite, linkErrorEvent} = 4'h0;
  // one-cycle pulse: 0 wake, 1 sleep, 2 page-zero write, 3 link error
  task automatic send(input int kind);
    @(posedge core_clk);
    {wakeCmd, sleepCmd, page0LinkWrite, linkErrorEvent} <= 4'h8 >> kind;
    @(posedge core_clk);
    {wakeCmd, sleepCmd, page0LinkWrite, linkErrorEvent} <= 4'h0;
  endtask
  // checksum bit only trusted once the quiet time has run out
  always @(posedge core_clk) quiet <= page0LinkWrite ? 0 : quiet + 1;
  assign csumReadOk = quiet > QUIET;
endmodule
`default_nettype wire

// ---- dsr_status_bank_tb.sv ----
// self-checking bench for the display status readback bank
// assumes dsr_link_host.sv and shortened settle and quiet counts
`timescale 1ns/100ps
`default_nettype none
module dsr_status_bank_tb;
  localparam int SETTLE = 8; // short wake settle window
  localparam int QUIET = 20; // short checksum quiet time
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic teLineEnable = 1'b0;
  logic teLineMode = 1'b0;
  logic nvmLoadMatch = 1'b0;
  logic funcCheckPass = 1'b0;
  logic checksumDiffer = 1'b0;
  dsr_status_pkg::dsr_byte_t regRdData;
  logic diagBusy, asleep, irq, wakeCmd, sleepCmd, page0LinkWrite, linkErrorEvent, csumReadOk;
  int n_fail = 0;
  int num_checks = 0;
  int n = 0; // busy cycles since the last wake
  logic [31:0] rnd = 32'hb541340f; // xorshift state
  logic [7:0] got; // last byte read
  logic d7 = 1'b0, d6 = 1'b0; // expected toggle bits of the diag byte
  always #10 core_clk = ~core_clk;
  // settle window length, counted from the wake pulse
  always @(posedge core_clk) n <= wakeCmd ? 0 : n + int'(diagBusy === 1'b1);
  dsr_status_bank #(.SETTLE_CYCLES(SETTLE), .CSUM_WAIT_CYCLES(QUIET)) u_dut (
    .core_clk(core_clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .teLineEnable(teLineEnable), .teLineMode(teLineMode), .linkErrorEvent(linkErrorEvent),
    .wakeCmd(wakeCmd), .sleepCmd(sleepCmd), .page0LinkWrite(page0LinkWrite),
    .nvmLoadMatch(nvmLoadMatch), .funcCheckPass(funcCheckPass),
    .checksumDiffer(checksumDiffer), .diagBusy(diagBusy), .asleep(asleep), .irq(irq));
  dsr_link_host #(.QUIET(QUIET)) u_host (
    .core_clk(core_clk), .wakeCmd(wakeCmd), .sleepCmd(sleepCmd),
    .page0LinkWrite(page0LinkWrite), .linkErrorEvent(linkErrorEvent), .csumReadOk(csumReadOk));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // one compare, counted; mismatches reported at once
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask
  // one-cycle read strobe; data only stands in the following cycle
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 got = regRdData;
  endtask
  // fresh tearing line state from the generator
  task automatic rand_te;
    @(posedge core_clk);
    rnd = xs(rnd);
    {teLineEnable, teLineMode} <= rnd[1:0];
  endtask
  // wake, read while settling, then check length and diag byte
  task automatic wake;
    u_host.send(0);
    rd(8'h0e); check("settle signal mode", got, {teLineEnable, teLineMode, 6'h00});
    repeat (2 * SETTLE) @(posedge core_clk);
    #1 check("settle length", 8'(n == SETTLE), 8'h01);
    check("awake", asleep, 8'h00);
    d7 ^= nvmLoadMatch;
    d6 ^= funcCheckPass;
    rd(8'h0f); check("diag byte", got, {d7, d6, 5'h00, checksumDiffer});
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #200000;
    n_fail++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    rd(8'h0d); check("image mode", got, 8'h00);
    rd(8'h0f); check("diag reset", got, 8'h00);
    rd(8'h40); check("unmapped", got, 8'h00);
    check("asleep", asleep, 8'h01);
    // signal-mode byte asleep, with a write to it that must be ignored
    for (int i = 0; i < 6; i++) begin
      rand_te();
      if (i == 3) wr(8'h0e, 8'hff);
      rd(8'h0e); check("signal mode", got, {teLineEnable, teLineMode, 6'h00});
    end
    // every load/function outcome pair across repeated wakes
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk);
      {nvmLoadMatch, funcCheckPass} <= 2'(k);
      checksumDiffer <= k[0];
      rand_te();
      wake();
      if (k < 3) u_host.send(1);
    end
    // link error: masked first, then unmasked, then cleared
    rd(8'h80); check("int status wakes", got, 8'h06);
    wr(8'h80, 8'h07);
    u_host.send(3);
    repeat (2) @(posedge core_clk);
    #1 check("irq masked", irq, 8'h00);
    rd(8'h80); check("int status", got, 8'h01);
    wr(8'h81, 8'h01);
    repeat (2) @(posedge core_clk);
    #1 check("irq raised", irq, 8'h01);
    rd(8'h0e); check("link error", got, {teLineEnable, teLineMode, 6'h01});
    // read data stands for one cycle only, then falls back to zero
    @(posedge core_clk);
    #1 check("read data one cycle", regRdData, 8'h00);
    rd(8'h0e); check("link error read", got, {teLineEnable, teLineMode, 6'h00});
    wr(8'h80, 8'h01);
    repeat (2) @(posedge core_clk);
    #1 check("irq cleared", irq, 8'h00);
    // checksum bit after the host's quiet time, both outcomes
    // the comparison changes on the write edge, so the old bit must hold until quiet
    for (int v = 0; v < 2; v++) begin
      u_host.send(2);
      checksumDiffer <= v[0];
      rd(8'h82); check("quiet status", got, 8'h03);
      rd(8'h0f); check("checksum held", got, {d7, d6, 5'h00, ~v[0]});
      while (csumReadOk !== 1'b1) @(posedge core_clk);
      rd(8'h82); check("settled status", got, 8'h07);
      rd(8'h0f); check("checksum", got, {d7, d6, 5'h00, v[0]});
    end
    rd(8'h80); check("settled events", got, 8'h04);
    complete_run();
  end
endmodule
`default_nettype wire
